// ### rxirq_host.sv
// Host model driving the register port of the receiver interrupt router
`timescale 1ns/1ps
module rxirq_host
  import rxirq_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register access port
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
  endtask

  // Flags never self-clear, so the host writes ones to drop them
  task automatic clear_flags(input logic [7:0] m);
    wr(RXIRQ_OFS_CLEAR, m);
  endtask
endmodule // rxirq_host

// ### rxirq_pkg.sv
// Package with register map, field positions and mode codes of the receiver interrupt router
package rxirq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RXIRQ_OFS_ENABLE = 8'h3F;
  localparam logic [7:0] RXIRQ_OFS_SELECT = 8'h41;
  localparam logic [7:0] RXIRQ_OFS_CLEAR = 8'h42;
  localparam logic [7:0] RXIRQ_OFS_STATUS = 8'h43;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RXIRQ_RST_ENABLE = 8'h00;
  localparam logic [7:0] RXIRQ_RST_SELECT = 8'h00;
  localparam logic [7:0] RXIRQ_RST_STATUS = 8'h00;
  localparam logic [7:0] RXIRQ_RST_RDATA = 8'h00;

  // ----------------------------------------------------------------
  // Flag, enable and clear bit positions (shared layout)
  // ----------------------------------------------------------------
  localparam int RXIRQ_BIT_SLEEP_TMO = 7;
  localparam int RXIRQ_BIT_RECEIVE_TIMEOUT_EVT = 6;
  localparam int RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT = 5;
  localparam int RXIRQ_BIT_PREAMBLE = 4;
  localparam int RXIRQ_BIT_SYNCWORD = 3;
  localparam int RXIRQ_BIT_NODE = 2;
  localparam int RXIRQ_BIT_CHECKSUM = 1;
  localparam int RXIRQ_BIT_PACKET = 0;
  localparam int RXIRQ_NUM_FLAGS = 8;

  // ----------------------------------------------------------------
  // Selector field positions
  // ----------------------------------------------------------------
  localparam int RXIRQ_SEL_A_LSB = 0;
  localparam int RXIRQ_SEL_B_LSB = 4;
  localparam int RXIRQ_SEL_WIDTH = 4;

  // ----------------------------------------------------------------
  // Data modes and operating states
  // ----------------------------------------------------------------
  localparam logic [1:0] RXIRQ_MODE_DIRECT = 2'h0;
  localparam logic [1:0] RXIRQ_MODE_BUFFER = 2'h1;
  localparam logic [1:0] RXIRQ_MODE_PACKET = 2'h2;

  localparam logic [2:0] RXIRQ_ST_SLEEP = 3'h1;
  localparam logic [2:0] RXIRQ_ST_STANDBY = 3'h2;
  localparam logic [2:0] RXIRQ_ST_TUNE = 3'h3;
  localparam logic [2:0] RXIRQ_ST_RECEIVE = 3'h4;
  localparam logic [2:0] RXIRQ_ST_NVM = 3'h5;

endpackage

// ### rxirq_route.sv
// Interrupt routing, enable, sticky flags and clear logic of the receiver
// Function
// R01: Bits 3:0 of the select register choose the event on line A.
// R02: Packet mode codes map fourteen events, code zero drives zero.
// R03: Direct mode codes one to six select events; bits 7:4 select line B.
// R04: Buffer mode codes one to eleven select events, others drive zero.
// R05: Queue write strobe is a one-cycle routable pulse with no latched flag.
// R06: Clear register is write-only; a one clears the matching flag.
// R07: Clear writes act only in standby, tune, receive or memory-access state.
// R08: Sleep timeout flag sets at expiry when timer runs and enabled.
// R09: Receive timeout flag sets at expiry when timer runs and enabled.
// R10: Signal valid flag sets under frequency-shift demodulation when enabled.
// R11: Preamble flag sets on preamble success when enabled; cleared by clear bit.
// R12: Syncword flag sets on syncword match when enabled; cleared by clear bit.
// R13: Node flag sets only in packet mode on node match when enabled.
// R14: Checksum flag sets only in packet mode on good checksum when enabled.
// R15: Packet flag sets in packet mode on any full packet when enabled.
// R16: Host clears the packet flag by writing one; it never self-clears.
// R17: Status flags are read-only; host writes leave them unchanged.
// R18: Enable register holds one bit per latched event, all disabled after reset.
`timescale 1ns/1ps
module rxirq_route
  import rxirq_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register access port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Device context
  input wire logic [1:0] data_mode,
  input wire logic [2:0] op_state,
  input wire logic fsk_demod,
  input wire logic sleep_timer_running,
  input wire logic rx_timer_running,
  // Latched event sources, one-cycle pulses
  input wire logic sleep_timeout_evt,
  input wire logic receive_timeout_evt,
  input wire logic signal_strength_valid_evt,
  input wire logic preamble_pass_evt,
  input wire logic syncword_pass_evt,
  input wire logic node_match_evt,
  input wire logic checksum_pass_evt,
  input wire logic packet_received_evt,
  // Routed-only sources
  input wire logic queue_not_empty_evt,
  input wire logic queue_threshold_evt,
  input wire logic queue_full_evt,
  input wire logic queue_byte_write_strobe,
  input wire logic queue_overflow_evt,
  input wire logic signal_strength_indicator,
  // Interrupt lines
  output logic irq_out_a,
  output logic irq_out_b
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] irq_enable;
  logic [7:0] irq_line_source_select;
  logic [7:0] irq_flag_status;
  logic [RXIRQ_SEL_WIDTH-1:0] irq_a_source_sel;
  logic [RXIRQ_SEL_WIDTH-1:0] irq_b_source_sel;
  logic [7:0] evt_raw;
  logic [7:0] evt_qual;
  logic [7:0] next_flags;
  logic clear_allowed;
  logic clear_write;
  logic is_packet;
  logic [1:0] line_sel;

  assign irq_a_source_sel = irq_line_source_select[RXIRQ_SEL_A_LSB +: RXIRQ_SEL_WIDTH]; // R01
  assign irq_b_source_sel = irq_line_source_select[RXIRQ_SEL_B_LSB +: RXIRQ_SEL_WIDTH]; // R03
  assign is_packet = (data_mode == RXIRQ_MODE_PACKET);
  assign clear_allowed = (op_state == RXIRQ_ST_STANDBY) || (op_state == RXIRQ_ST_TUNE) ||
                         (op_state == RXIRQ_ST_RECEIVE) || (op_state == RXIRQ_ST_NVM); // R07
  assign clear_write = reg_wr_en && (reg_addr == RXIRQ_OFS_CLEAR) && clear_allowed; // R06 R07

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_enable <= RXIRQ_RST_ENABLE; // R18
    end else if (ce && reg_wr_en && reg_addr == RXIRQ_OFS_ENABLE) begin
      irq_enable <= reg_wdata; // R18
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_line_source_select <= RXIRQ_RST_SELECT;
    end else if (ce && reg_wr_en && reg_addr == RXIRQ_OFS_SELECT) begin
      irq_line_source_select <= reg_wdata; // R01 R03
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  always_comb begin
    evt_raw = 8'h00;
    evt_raw[RXIRQ_BIT_SLEEP_TMO] = sleep_timeout_evt;
    evt_raw[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT] = receive_timeout_evt;
    evt_raw[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT] = signal_strength_valid_evt;
    evt_raw[RXIRQ_BIT_PREAMBLE] = preamble_pass_evt;
    evt_raw[RXIRQ_BIT_SYNCWORD] = syncword_pass_evt;
    evt_raw[RXIRQ_BIT_NODE] = node_match_evt;
    evt_raw[RXIRQ_BIT_CHECKSUM] = checksum_pass_evt;
    evt_raw[RXIRQ_BIT_PACKET] = packet_received_evt;
  end

  always_comb begin
    evt_qual = 8'hFF;
    evt_qual[RXIRQ_BIT_SLEEP_TMO] = sleep_timer_running; // R08
    evt_qual[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT] = rx_timer_running; // R09
    evt_qual[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT] = fsk_demod; // R10
    evt_qual[RXIRQ_BIT_NODE] = is_packet; // R13
    evt_qual[RXIRQ_BIT_CHECKSUM] = is_packet; // R14
    evt_qual[RXIRQ_BIT_PACKET] = is_packet; // R15
  end

  // Set beats a clear landing in the same cycle, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < RXIRQ_NUM_FLAGS; gi++) begin : g_flag
      logic set_now;
      logic clear_now;
      assign set_now = evt_raw[gi] && evt_qual[gi] && irq_enable[gi]; // R08 R09 R10 R11 R12
      assign clear_now = clear_write && reg_wdata[gi]; // R06 R11 R12 R16
      assign next_flags[gi] = set_now || (irq_flag_status[gi] && !clear_now); // R13 R14 R15
    end
  endgenerate

  // Status register takes no host writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_flag_status <= RXIRQ_RST_STATUS;
    end else if (ce) begin
      irq_flag_status <= next_flags; // R17
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RXIRQ_RST_RDATA;
    end else if (ce && reg_rd_en) begin
      unique case (reg_addr)
        RXIRQ_OFS_ENABLE: reg_rdata <= irq_enable;
        RXIRQ_OFS_SELECT: reg_rdata <= irq_line_source_select;
        RXIRQ_OFS_STATUS: reg_rdata <= irq_flag_status;
        default: reg_rdata <= RXIRQ_RST_RDATA; // R06
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line routing
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      rxirq_src_mux u_mux (
        .data_mode(data_mode),
        .source_sel(gi == 0 ? irq_a_source_sel : irq_b_source_sel),
        .flags(irq_flag_status),
        .queue_not_empty_evt(queue_not_empty_evt),
        .queue_threshold_evt(queue_threshold_evt),
        .queue_full_evt(queue_full_evt),
        .queue_byte_write_strobe(queue_byte_write_strobe),
        .queue_overflow_evt(queue_overflow_evt),
        .signal_strength_indicator(signal_strength_indicator),
        .selected(line_sel[gi])
      );
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end else if (ce) begin
      irq_out_a <= line_sel[0]; // R01
      irq_out_b <= line_sel[1]; // R03
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_clear_ok(int b);
    ce && clear_write && reg_wdata[b] && !(evt_raw[b] && evt_qual[b] && irq_enable[b]);
  endsequence

  property p_clear_packet;
    s_clear_ok(0) |=> !irq_flag_status[RXIRQ_BIT_PACKET];
  endproperty
  a_clear_packet: assert property (p_clear_packet) else $error("packet flag not cleared"); // R06

  property p_clear_ignored;
    ce && reg_wr_en && reg_addr == RXIRQ_OFS_CLEAR && !clear_allowed
      |=> ($past(irq_flag_status) & ~irq_flag_status) == 8'h00;
  endproperty
  a_clear_ignored: assert property (p_clear_ignored) else $error("clear acted in bad state"); // R07

  property p_set_wins;
    ce && syncword_pass_evt && irq_enable[RXIRQ_BIT_SYNCWORD] |=> irq_flag_status[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("syncword flag not set"); // R12

  property p_sleep_needs_timer;
    ce && !irq_flag_status[7] && !sleep_timer_running |=> !irq_flag_status[7];
  endproperty
  a_sleep_needs_timer: assert property (p_sleep_needs_timer) else $error("sleep flag w/o timer"); // R08

  property p_node_packet_only;
    ce && !irq_flag_status[2] && !is_packet |=> !irq_flag_status[2];
  endproperty
  a_node_packet_only: assert property (p_node_packet_only) else $error("node flag off mode"); // R13

  property p_packet_sticky;
    ce && irq_flag_status[0] && !clear_write |=> irq_flag_status[0];
  endproperty
  a_packet_sticky: assert property (p_packet_sticky) else $error("packet flag self-cleared"); // R16

  property p_status_ro;
    ce && reg_wr_en && reg_addr == RXIRQ_OFS_STATUS && evt_raw == 8'h00
      |=> irq_flag_status == $past(irq_flag_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write"); // R17

  property p_strobe_route;
    ce && is_packet && irq_a_source_sel == 4'hC && queue_byte_write_strobe |=> irq_out_a;
  endproperty
  a_strobe_route: assert property (p_strobe_route) else $error("write strobe not routed"); // R05

  property p_direct_zero;
    ce && data_mode == RXIRQ_MODE_DIRECT && irq_b_source_sel >= 4'h7 |=> !irq_out_b;
  endproperty
  a_direct_zero: assert property (p_direct_zero) else $error("direct high code not zero"); // R03

  property p_enable_gate;
    ce && !irq_enable[4] && !irq_flag_status[4] |=> !irq_flag_status[4];
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("preamble flag while disabled"); // R11

  sequence s_set_ok(int b);
    ce && evt_raw[b] && evt_qual[b] && irq_enable[b];
  endsequence

  property p_ce_freeze;
    !ce |=> $stable(irq_flag_status) && $stable(irq_enable) && $stable(irq_line_source_select);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state not frozen"); // R17

  property p_ce_freeze_out;
    !ce |=> $stable(irq_out_a) && $stable(irq_out_b) && $stable(reg_rdata);
  endproperty
  a_ce_freeze_out: assert property (p_ce_freeze_out) else $error("output not frozen"); // R01

  property p_rx_needs_timer;
    ce && !irq_flag_status[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT] && !rx_timer_running
      |=> !irq_flag_status[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT];
  endproperty
  a_rx_needs_timer: assert property (p_rx_needs_timer) else $error("rx flag w/o timer"); // R09

  property p_rssi_needs_fsk;
    ce && !irq_flag_status[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT] && !fsk_demod
      |=> !irq_flag_status[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT];
  endproperty
  a_rssi_needs_fsk: assert property (p_rssi_needs_fsk) // R10
    else $error("valid flag w/o fsk");

  property p_sum_packet_only;
    ce && !irq_flag_status[RXIRQ_BIT_CHECKSUM] && !is_packet
      |=> !irq_flag_status[RXIRQ_BIT_CHECKSUM];
  endproperty
  a_sum_packet_only: assert property (p_sum_packet_only) // R14
    else $error("checksum flag off mode");

  property p_packet_set;
    s_set_ok(RXIRQ_BIT_PACKET) |=> irq_flag_status[RXIRQ_BIT_PACKET];
  endproperty
  a_packet_set: assert property (p_packet_set) else $error("packet flag not set"); // R15

  property p_sleep_set;
    s_set_ok(RXIRQ_BIT_SLEEP_TMO) |=> irq_flag_status[RXIRQ_BIT_SLEEP_TMO];
  endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep flag not set"); // R08

  property p_sync_clear;
    s_clear_ok(RXIRQ_BIT_SYNCWORD) |=> !irq_flag_status[RXIRQ_BIT_SYNCWORD];
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("syncword flag not cleared"); // R12

  property p_code_zero;
    ce && irq_a_source_sel == 4'h0 |=> !irq_out_a;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code zero not quiet"); // R02

  property p_buffer_zero;
    ce && data_mode == RXIRQ_MODE_BUFFER && irq_a_source_sel >= 4'hC |=> !irq_out_a;
  endproperty
  a_buffer_zero: assert property (p_buffer_zero) else $error("buffer high code not zero"); // R04

  property p_rd_status;
    ce && reg_rd_en && reg_addr == RXIRQ_OFS_STATUS |=> reg_rdata == $past(irq_flag_status);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read-back wrong"); // R17

  property p_rd_clear;
    ce && reg_rd_en && reg_addr == RXIRQ_OFS_CLEAR |=> reg_rdata == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("clear register readable"); // R06

endmodule // rxirq_route

// ### rxirq_src_mux.sv
// Event selector for one interrupt line, mapping depends on the data mode
`timescale 1ns/1ps
module rxirq_src_mux
  import rxirq_pkg::*;
(
  // Selection
  input wire logic [1:0] data_mode,
  input wire logic [RXIRQ_SEL_WIDTH-1:0] source_sel,
  // Latched flags
  input wire logic [RXIRQ_NUM_FLAGS-1:0] flags,
  // Queue and signal levels
  input wire logic queue_not_empty_evt,
  input wire logic queue_threshold_evt,
  input wire logic queue_full_evt,
  input wire logic queue_byte_write_strobe,
  input wire logic queue_overflow_evt,
  input wire logic signal_strength_indicator,
  // Selected event
  output logic selected
);

  always_comb begin
    selected = 1'b0;
    if (data_mode == RXIRQ_MODE_PACKET) begin
      unique case (source_sel)
        4'h1: selected = flags[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT]; // R02
        4'h2: selected = flags[RXIRQ_BIT_PREAMBLE];
        4'h3: selected = flags[RXIRQ_BIT_SYNCWORD];
        4'h4: selected = flags[RXIRQ_BIT_NODE];
        4'h5: selected = flags[RXIRQ_BIT_CHECKSUM];
        4'h6: selected = flags[RXIRQ_BIT_PACKET];
        4'h7: selected = flags[RXIRQ_BIT_SLEEP_TMO];
        4'h8: selected = flags[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT];
        4'h9: selected = queue_not_empty_evt;
        4'hA: selected = queue_threshold_evt;
        4'hB: selected = queue_full_evt;
        4'hC: selected = queue_byte_write_strobe; // R05
        4'hD: selected = queue_overflow_evt;
        4'hE: selected = signal_strength_indicator;
        default: selected = 1'b0;
      endcase
    end else if (data_mode == RXIRQ_MODE_BUFFER) begin
      unique case (source_sel)
        4'h1: selected = flags[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT]; // R04
        4'h2: selected = flags[RXIRQ_BIT_PREAMBLE];
        4'h3: selected = flags[RXIRQ_BIT_SYNCWORD];
        4'h4: selected = flags[RXIRQ_BIT_SLEEP_TMO];
        4'h5: selected = flags[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT];
        4'h6: selected = queue_not_empty_evt;
        4'h7: selected = queue_threshold_evt;
        4'h8: selected = queue_full_evt;
        4'h9: selected = queue_byte_write_strobe; // R05
        4'hA: selected = queue_overflow_evt;
        4'hB: selected = signal_strength_indicator;
        default: selected = 1'b0;
      endcase
    end else if (data_mode == RXIRQ_MODE_DIRECT) begin
      unique case (source_sel)
        4'h1: selected = flags[RXIRQ_BIT_SIGNAL_STRENGTH_VALID_EVT]; // R03
        4'h2: selected = flags[RXIRQ_BIT_PREAMBLE];
        4'h3: selected = flags[RXIRQ_BIT_SYNCWORD];
        4'h4: selected = flags[RXIRQ_BIT_SLEEP_TMO];
        4'h5: selected = flags[RXIRQ_BIT_RECEIVE_TIMEOUT_EVT];
        4'h6: selected = signal_strength_indicator;
        default: selected = 1'b0;
      endcase
    end
  end

endmodule // rxirq_src_mux

// ### testbench.sv
// Self-checking testbench of the receiver interrupt router
`timescale 1ns/1ps
module testbench
  import rxirq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Source index per code, one nibble each; index 14 is constant zero
  localparam logic [63:0] ROUTE_MAP [4] = '{64'hEEEE_EEEE_ED67_345E,
    64'hEEEE_DCBA_9867_345E, 64'hEDCB_A986_7012_345E, 64'hEEEE_EEEE_EEEE_EEEE};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [1:0] data_mode = RXIRQ_MODE_PACKET;
  logic [2:0] op_state = RXIRQ_ST_STANDBY;
  logic fsk_demod = 1'b1;
  logic slp_run = 1'b1;
  logic rx_run = 1'b1;
  logic [7:0] evt = 8'h00;
  // Levels: indicator, overflow, strobe, full, threshold, not empty
  logic [5:0] lv = 6'h00;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq_a;
  logic irq_b;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q [$];
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] f;
  logic ok_st;

  initial begin
    forever #2 mclk = ~mclk;
  end

  rxirq_route DUT (.mclk(mclk), .resetn(resetn), .ce(ce), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .data_mode(data_mode), .op_state(op_state), .fsk_demod(fsk_demod),
    .sleep_timer_running(slp_run), .rx_timer_running(rx_run),
    .sleep_timeout_evt(evt[7]), .receive_timeout_evt(evt[6]),
    .signal_strength_valid_evt(evt[5]), .preamble_pass_evt(evt[4]),
    .syncword_pass_evt(evt[3]), .node_match_evt(evt[2]), .checksum_pass_evt(evt[1]),
    .packet_received_evt(evt[0]), .queue_not_empty_evt(lv[0]),
    .queue_threshold_evt(lv[1]), .queue_full_evt(lv[2]), .queue_byte_write_strobe(lv[3]),
    .queue_overflow_evt(lv[4]), .signal_strength_indicator(lv[5]),
    .irq_out_a(irq_a), .irq_out_b(irq_b));

  rxirq_host host (.mclk(mclk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata));

  // ----------------------------------------------------------------
  // Tasks and monitor
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
    n_compared++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge mclk);
    evt <= m;
    @(posedge mclk);
    evt <= 8'h00;
  endtask

  function automatic logic pick(input logic [1:0] m, input logic [3:0] c);
    logic [14:0] src;
    src = {1'b0, lv, f};
    return src[ROUTE_MAP[m][{c, 2'b00} +: 4]];
  endfunction

  // Read data is due one edge after the read is taken
  always @(posedge mclk) begin
    if (rd_seen) begin
      check("reg_rdata", exp_q.pop_front(), rdata);
    end
    rd_seen <= rd_en & ce;
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(93));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(RXIRQ_OFS_ENABLE, RXIRQ_RST_ENABLE);
    rd_chk(RXIRQ_OFS_SELECT, RXIRQ_RST_SELECT);
    rd_chk(RXIRQ_OFS_STATUS, RXIRQ_RST_STATUS);
    rd_chk(RXIRQ_OFS_CLEAR, 8'h00);
    rd_chk(8'h50, 8'h00);
    host.wr(RXIRQ_OFS_ENABLE, 8'hA5);
    rd_chk(RXIRQ_OFS_ENABLE, 8'hA5);
    host.wr(RXIRQ_OFS_SELECT, 8'h3C);
    rd_chk(RXIRQ_OFS_SELECT, 8'h3C);
    host.wr(RXIRQ_OFS_ENABLE, 8'hFF);
    $display("test registers done");
    // Qualifiers off: only preamble and syncword may latch
    host.clear_flags(8'hFF);
    @(posedge mclk);
    data_mode <= RXIRQ_MODE_DIRECT;
    fsk_demod <= 1'b0;
    slp_run <= 1'b0;
    rx_run <= 1'b0;
    pulse(8'hFF);
    rd_chk(RXIRQ_OFS_STATUS, 8'h18);
    host.wr(RXIRQ_OFS_ENABLE, 8'h00);
    host.clear_flags(8'hFF);
    @(posedge mclk);
    data_mode <= RXIRQ_MODE_PACKET;
    fsk_demod <= 1'b1;
    slp_run <= 1'b1;
    rx_run <= 1'b1;
    pulse(8'hFF);
    rd_chk(RXIRQ_OFS_STATUS, 8'h00);
    host.wr(RXIRQ_OFS_ENABLE, 8'h81);
    pulse(8'hFF);
    rd_chk(RXIRQ_OFS_STATUS, 8'h81);
    host.wr(RXIRQ_OFS_STATUS, 8'h00);
    rd_chk(RXIRQ_OFS_STATUS, 8'h81);
    host.wr(RXIRQ_OFS_ENABLE, 8'hFF);
    $display("test flag gating done");
    host.clear_flags(8'hFF);
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      op_state <= 3'(s);
      ok_st = (s >= 2 && s <= 5);
      pulse(8'h01);
      host.clear_flags(8'h01);
      rd_chk(RXIRQ_OFS_STATUS, {7'h00, ~ok_st});
    end
    @(posedge mclk);
    op_state <= RXIRQ_ST_STANDBY;
    $display("test clear states done");
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      data_mode <= RXIRQ_MODE_PACKET;
      host.clear_flags(8'hFF);
      f = 8'($urandom);
      pulse(f);
      rd_chk(RXIRQ_OFS_STATUS, f);
      @(posedge mclk);
      data_mode <= 2'(m);
      for (int c = 0; c < 16; c++) begin
        @(posedge mclk);
        lv <= 6'($urandom);
        host.wr(RXIRQ_OFS_SELECT, {4'(15 - c), 4'(c)});
        repeat (2) @(posedge mclk);
        #1;
        check("irq_out_a", {7'h00, pick(2'(m), 4'(c))}, {7'h00, irq_a});
        check("irq_out_b", {7'h00, pick(2'(m), 4'(15 - c))}, {7'h00, irq_b});
      end
    end
    $display("test routing done");
    @(posedge mclk);
    data_mode <= RXIRQ_MODE_BUFFER;
    lv <= 6'h00;
    host.clear_flags(8'hFF);
    host.wr(RXIRQ_OFS_SELECT, 8'h99);
    @(posedge mclk);
    lv <= 6'h08;
    @(posedge mclk);
    lv <= 6'h00;
    #1;
    check("irq_out_a", 8'h01, {7'h00, irq_a});
    check("irq_out_b", 8'h01, {7'h00, irq_b});
    @(posedge mclk);
    #1;
    check("irq_out_a", 8'h00, {7'h00, irq_a});
    rd_chk(RXIRQ_OFS_STATUS, 8'h00);
    $display("test write strobe done");
    // Clock enable low: events and writes are ignored
    host.clear_flags(8'hFF);
    @(posedge mclk);
    ce <= 1'b0;
    pulse(8'hFF);
    host.wr(RXIRQ_OFS_ENABLE, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk(RXIRQ_OFS_STATUS, 8'h00);
    rd_chk(RXIRQ_OFS_ENABLE, 8'hFF);
    // Event and clear in one cycle: the set wins
    fork
      pulse(8'h08);
      host.clear_flags(8'h08);
    join
    rd_chk(RXIRQ_OFS_STATUS, 8'h08);
    $display("test clock enable done");
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(RXIRQ_OFS_STATUS, RXIRQ_RST_STATUS);
    rd_chk(RXIRQ_OFS_ENABLE, RXIRQ_RST_ENABLE);
    rd_chk(RXIRQ_OFS_SELECT, RXIRQ_RST_SELECT);
    $display("test mid-run reset done");
    repeat (3) @(posedge mclk);
    test_done();
  end
endmodule // testbench
